// *** inc/nrre_pkg.sv ***
package nrre_pkg;

    // ==========================================================
    // Opcode patterns, upper bits or whole instruction word
    // ==========================================================
    localparam logic [6:0]  OP_NEGATE_HI7     = 7'h16;   // 0010 110s
    localparam logic [6:0]  OP_ROT_LEFT_HI7   = 7'h11;   // 0010 001d
    localparam logic [6:0]  OP_ROT_LC_HI7     = 7'h0d;   // 0001 101d
    localparam logic [6:0]  OP_ROT_RC_HI7     = 7'h0c;   // 0001 100d
    localparam logic [7:0]  OP_RET_LIT_HI8    = 8'hb6;   // 1011 0110
    localparam logic [15:0] OP_RETURN         = 16'h0002;
    localparam logic [15:0] OP_RET_INT        = 16'h0005;
    localparam logic [15:0] OP_NOP            = 16'h0000;

    // ==========================================================
    // Field positions and reset values
    // ==========================================================
    localparam int          SEL_BIT_POS       = 8;       // s or d bit
    localparam int          GLOBAL_INT_DISABLE_POS        = 4;       // cpu_status_reg bit
    localparam int          OVF_POS           = 3;
    localparam int          ZERO_POS          = 2;
    localparam int          DC_POS            = 1;
    localparam int          CARRY_POS         = 0;
    localparam logic [7:0]  WORKING_RESET     = 8'h00;
    localparam logic [7:0]  CPU_STATUS_RESET  = 8'h10;
    localparam logic [7:0]  ALU_STATUS_RESET  = 8'h00;
    localparam logic [15:0] PC_RESET          = 16'h0000;
    localparam logic [7:0]  PC_HIGH_RESET     = 8'h00;
    localparam logic [1:0]  PHASE_LAST        = 2'h3;    // four phases a cycle

    // ==========================================================
    // Types
    // ==========================================================
    typedef enum logic [2:0] {
        NRRE_OP_NOP,
        NRRE_OP_NEGATE,
        NRRE_OP_ROT_LC,
        NRRE_OP_ROT_LEFT,
        NRRE_OP_ROT_RC,
        NRRE_OP_RETURN,
        NRRE_OP_RET_INT,
        NRRE_OP_RET_LIT
    } nrre_op_type;

    typedef struct packed {
        logic [7:0] result;
        logic       carry;
        logic       digit_carry;
        logic       overflow;
        logic       zero;
    } nrre_alu_type;

    typedef struct packed {
        logic       write_en;
        logic [7:0] addr;
        logic [7:0] data;
    } nrre_mem_wr_type;

endpackage

// *** logic/nrre_alu.sv ***
`timescale 1ns/100ps
// Combinational datapath for negate and rotate operations
module nrre_alu (
    // Operation select
    input  wire nrre_pkg::nrre_op_type op,
    // Operands
    input  wire logic [7:0]            working,
    input  wire logic [7:0]            file_data,
    input  wire logic                  carry_in,
    // Result and flags
    output nrre_pkg::nrre_alu_type     alu
);

    logic [4:0] low_sum;
    logic [8:0] full_sum;
    logic [7:0] inv_w;

    // ==========================================================
    // Result selection
    // ==========================================================
    always_comb begin
        inv_w    = ~working;
        low_sum  = {1'b0, inv_w[3:0]} + 5'h01;
        full_sum = {1'b0, inv_w} + 9'h001;
        alu      = '0;
        case (op)
            nrre_pkg::NRRE_OP_NEGATE: begin
                alu.result      = full_sum[7:0];
                alu.carry       = full_sum[8];
                alu.digit_carry = low_sum[4];
                // Only 0x80 overflows: sign of a negative source stays negative
                alu.overflow    = (inv_w[7] == 1'b0) && full_sum[7];
                alu.zero        = (full_sum[7:0] == 8'h00);
            end
            nrre_pkg::NRRE_OP_ROT_LC: begin
                alu.result = {file_data[6:0], carry_in};
                alu.carry  = file_data[7];
            end
            nrre_pkg::NRRE_OP_ROT_LEFT: begin
                alu.result = {file_data[6:0], file_data[7]};
            end
            nrre_pkg::NRRE_OP_ROT_RC: begin
                alu.result = {carry_in, file_data[7:1]};
                alu.carry  = file_data[0];
            end
            default: begin
                alu = '0;
            end
        endcase
    end

endmodule

// *** logic/nrre_core.sv ***
`timescale 1ns/100ps
module nrre_core (
    // Clock and reset
    input  wire logic                  clock,
    input  wire logic                  rst,
    // Program memory
    input  wire logic [15:0]           instr_word,
    output logic      [15:0]           prog_addr,
    // Data memory register file
    input  wire logic [7:0]            file_rd_data,
    output logic      [7:0]            file_rd_addr,
    output nrre_pkg::nrre_mem_wr_type  file_wr,
    // Hardware stack
    input  wire logic [15:0]           stack_top,
    output logic                       stack_pop,
    // Visible state
    output logic      [7:0]            working_reg,
    output logic      [7:0]            cpu_status_reg,
    output logic      [7:0]            alu_status_reg,
    output logic      [7:0]            pc_high_latch,
    output logic      [1:0]            q_phase,
    output logic                       idle_cycle
);

    // ==========================================================
    // State
    // ==========================================================
    // Whole core state in one record, registered in a single process
    typedef struct packed {
        logic [1:0]                 phase;
        logic                       idle;
        logic [15:0]                instr;
        logic [15:0]                pc;
        logic [7:0]                 working;
        logic [7:0]                 cpu_status;
        logic [7:0]                 alu_status;
        logic [7:0]                 pc_high;
        logic                       pop;
        nrre_pkg::nrre_mem_wr_type  wr;
    } nrre_state_type;

    // ==========================================================
    // Signals
    // ==========================================================
    // Op is pure decode of state_q, alu also takes file_rd_data, so they settle each cycle
    nrre_state_type        state_q;
    nrre_state_type        state_d;
    nrre_pkg::nrre_op_type op;
    nrre_pkg::nrre_alu_type alu;
    logic                  sel_bit;

    // ==========================================================
    // Decode
    // ==========================================================
    function automatic nrre_pkg::nrre_op_type decode(input logic [15:0] w);
        nrre_pkg::nrre_op_type o;
        o = nrre_pkg::NRRE_OP_NOP;
        // Seven-bit patterns leave the s or d bit out of the match
        if (w[15:9] == nrre_pkg::OP_NEGATE_HI7) begin
            o = nrre_pkg::NRRE_OP_NEGATE;
        end else if (w[15:9] == nrre_pkg::OP_ROT_LC_HI7) begin
            o = nrre_pkg::NRRE_OP_ROT_LC;
        end else if (w[15:9] == nrre_pkg::OP_ROT_LEFT_HI7) begin
            o = nrre_pkg::NRRE_OP_ROT_LEFT;
        end else if (w[15:9] == nrre_pkg::OP_ROT_RC_HI7) begin
            o = nrre_pkg::NRRE_OP_ROT_RC;
        end else if (w[15:8] == nrre_pkg::OP_RET_LIT_HI8) begin
            o = nrre_pkg::NRRE_OP_RET_LIT;
        end else if (w == nrre_pkg::OP_RETURN) begin
            o = nrre_pkg::NRRE_OP_RETURN;
        end else if (w == nrre_pkg::OP_RET_INT) begin
            o = nrre_pkg::NRRE_OP_RET_INT;
        end else if (w == nrre_pkg::OP_NOP) begin
            o = nrre_pkg::NRRE_OP_NOP;
        end
        // Unknown words fall to no-operation so the core never hangs
        return o;
    endfunction

    // Instruction latched at Q1 is held for the whole cycle
    assign op      = state_q.idle ? nrre_pkg::NRRE_OP_NOP : decode(state_q.instr);
    assign sel_bit = state_q.instr[nrre_pkg::SEL_BIT_POS];

    // One datapath shared by negate and the rotates
    nrre_alu u_alu (
        .op        (op),
        .working   (state_q.working),
        .file_data (file_rd_data),
        .carry_in  (state_q.alu_status[nrre_pkg::CARRY_POS]),
        .alu       (alu)
    );

    // ==========================================================
    // Next state
    // ==========================================================
    always_comb begin
        state_d        = state_q;
        state_d.phase  = state_q.phase + 2'h1;
        state_d.pop    = 1'b0;
        state_d.wr     = '0;
        // Pulses default low so each write or pop stands one clock only
        // Q1: fetch the next word unless this cycle is the idle half of a return
        if (state_q.phase == 2'h0 && !state_q.idle) begin
            state_d.instr = instr_word;
        end
        // Q4: write back and advance
        // Memory read data is used only here, so it may arrive late
        if (state_q.phase == nrre_pkg::PHASE_LAST) begin
            state_d.idle = 1'b0;
            state_d.pc   = state_q.pc + 16'h0001;
            case (op)
                nrre_pkg::NRRE_OP_NEGATE: begin
                    // memory always, working only when s=0
                    state_d.wr.write_en = 1'b1;
                    state_d.wr.addr     = state_q.instr[7:0];
                    state_d.wr.data     = alu.result;
                    if (!sel_bit) begin
                        state_d.working = alu.result;
                    end
                    state_d.alu_status[nrre_pkg::CARRY_POS] = alu.carry;
                    state_d.alu_status[nrre_pkg::DC_POS]    = alu.digit_carry;
                    state_d.alu_status[nrre_pkg::OVF_POS]   = alu.overflow;
                    state_d.alu_status[nrre_pkg::ZERO_POS]  = alu.zero;
                end
                nrre_pkg::NRRE_OP_ROT_LC, nrre_pkg::NRRE_OP_ROT_RC,
                nrre_pkg::NRRE_OP_ROT_LEFT: begin
                    if (sel_bit) begin
                        state_d.wr.write_en = 1'b1;
                        state_d.wr.addr     = state_q.instr[7:0];
                        state_d.wr.data     = alu.result;
                    end else begin
                        state_d.working = alu.result;
                    end
                    if (op != nrre_pkg::NRRE_OP_ROT_LEFT) begin
                        state_d.alu_status[nrre_pkg::CARRY_POS] = alu.carry;
                    end
                end
                nrre_pkg::NRRE_OP_RET_INT: begin
                    // pop into PC, idle cycle follows
                    state_d.pc   = stack_top;
                    state_d.pop  = 1'b1;
                    state_d.idle = 1'b1;
                    state_d.cpu_status[nrre_pkg::GLOBAL_INT_DISABLE_POS] = 1'b0;
                end
                nrre_pkg::NRRE_OP_RETURN: begin
                    state_d.pc   = stack_top;
                    state_d.pop  = 1'b1;
                    state_d.idle = 1'b1;
                end
                nrre_pkg::NRRE_OP_RET_LIT: begin
                    state_d.working = state_q.instr[7:0];
                    state_d.pc      = stack_top;
                    state_d.pop     = 1'b1;
                    state_d.idle    = 1'b1;
                end
                default: begin
                    state_d.pc = state_q.pc + 16'h0001;
                end
            endcase
            // Idle half of a two-cycle return: PC already holds the target
            if (state_q.idle) begin
                state_d.pc = state_q.pc;
            end
        end
    end

    // ==========================================================
    // State register
    // ==========================================================
    // Asynchronous clear; every other update on the rising edge
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            // Constants only; the fields below refine the blanket clear
            state_q            <= '0;
            state_q.pc         <= nrre_pkg::PC_RESET;
            state_q.working    <= nrre_pkg::WORKING_RESET;
            state_q.cpu_status <= nrre_pkg::CPU_STATUS_RESET;
            state_q.alu_status <= nrre_pkg::ALU_STATUS_RESET;
            state_q.pc_high    <= nrre_pkg::PC_HIGH_RESET;
        end else begin
            state_q <= state_d;
        end
    end

    // ==========================================================
    // Outputs, all from flops
    // ==========================================================
    // Straight from state flops, so no output glitches between edges
    assign prog_addr      = state_q.pc;
    assign file_rd_addr   = state_q.instr[7:0];
    assign file_wr        = state_q.wr;
    assign stack_pop      = state_q.pop;
    assign working_reg    = state_q.working;
    assign cpu_status_reg = state_q.cpu_status;
    assign alu_status_reg = state_q.alu_status;
    assign pc_high_latch  = state_q.pc_high;
    assign q_phase        = state_q.phase;
    assign idle_cycle     = state_q.idle;

endmodule

// *** test/nrre_core_chk.sv ***
`timescale 1ns/100ps
// Port-level checks on the execution core
module nrre_chk (
    // Clock and reset
    input wire logic                      clock,
    input wire logic                      rst,
    // Observed ports
    input wire logic [15:0]               prog_addr,
    input wire logic [7:0]                file_rd_addr,
    input wire nrre_pkg::nrre_mem_wr_type file_wr,
    input wire logic [15:0]               stack_top,
    input wire logic                      stack_pop,
    input wire logic [7:0]                working_reg,
    input wire logic [7:0]                cpu_status_reg,
    input wire logic [7:0]                alu_status_reg,
    input wire logic [7:0]                pc_high_latch,
    input wire logic [1:0]                q_phase,
    input wire logic                      idle_cycle
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    // Results only as a new cycle begins
    property p_wr_phase; file_wr.write_en |-> q_phase == 2'h0 && !idle_cycle; endproperty
    a_wr_phase: assert property (p_wr_phase) else $error("write off cycle start");
    property p_wr_addr; file_wr.write_en |-> file_wr.addr == $past(file_rd_addr); endproperty
    a_wr_addr: assert property (p_wr_addr) else $error("write address wrong");
    property p_flag_phase; !$stable(alu_status_reg) |-> q_phase == 2'h0; endproperty
    a_flag_phase: assert property (p_flag_phase) else $error("flags moved mid cycle");
    // A pop is followed by exactly one idle cycle
    property p_pop_idle;
        stack_pop |-> idle_cycle ##1 (idle_cycle && !stack_pop) [*3] ##1 !idle_cycle;
    endproperty
    a_pop_idle: assert property (p_pop_idle) else $error("idle cycle length wrong");
    property p_pop_pc; stack_pop |-> prog_addr == stack_top && q_phase == 2'h0; endproperty
    a_pop_pc: assert property (p_pop_pc) else $error("pc not from stack");
    property p_idle_quiet;
        idle_cycle && $past(idle_cycle) |-> $stable(prog_addr) && $stable(working_reg);
    endproperty
    a_idle_quiet: assert property (p_idle_quiet) else $error("state moved while idle");
    property p_glint_only; $stable({cpu_status_reg[7:5], cpu_status_reg[3:0]}); endproperty
    a_glint_only: assert property (p_glint_only) else $error("status bit changed");
    property p_glint_clear; $fell(cpu_status_reg[4]) |-> stack_pop && idle_cycle; endproperty
    a_glint_clear: assert property (p_glint_clear) else $error("stray enable");
    property p_latch_hold; $stable(pc_high_latch); endproperty
    a_latch_hold: assert property (p_latch_hold) else $error("pc high latch moved");
    // Main scenarios reached
    c_pop: cover property (stack_pop);
    c_write: cover property (file_wr.write_en);
    c_glint: cover property ($fell(cpu_status_reg[4]));
endmodule
bind nrre_core nrre_chk u_chk (.clock, .rst, .prog_addr, .file_rd_addr, .file_wr, .stack_top,
    .stack_pop, .working_reg, .cpu_status_reg, .alu_status_reg, .pc_high_latch, .q_phase,
    .idle_cycle);

// *** test/nrre_mem_model.sv ***
`timescale 1ns/100ps
// Data memory and hardware stack facing the core
module nrre_mem_model (
    // Clock
    input  wire logic                      clock,
    // Data memory port
    input  wire logic [7:0]                file_rd_addr,
    output logic      [7:0]                file_rd_data,
    input  wire nrre_pkg::nrre_mem_wr_type file_wr,
    // Stack port
    output logic      [15:0]               stack_top,
    input  wire logic                      stack_pop
);
    logic [7:0]  mem [256];
    logic [15:0] stk [8];
    logic [2:0]  sp;
    // Distinct contents so a wrong address shows up
    initial begin
        sp = 3'h7;
        for (int i = 0; i < 256; i++) mem[i] = 8'(i * 8'h1d);
        for (int i = 0; i < 8; i++) stk[i] = 16'h1000 + 16'(i * 16'h111);
    end
    // Reads are combinational, the core samples them late in the cycle
    assign file_rd_data = mem[file_rd_addr];
    assign stack_top    = stk[sp];
    // Writes and pops land on the edge after the pulse
    always @(posedge clock) begin
        if (file_wr.write_en) mem[file_wr.addr] <= file_wr.data;
        if (stack_pop) sp <= sp - 3'h1;
    end
endmodule

// *** test/test_negate_return_rotate_exec.sv ***
`timescale 1ns/100ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin n_fail++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, (a), (b)); end end
module test_negate_return_rotate_exec;
    logic                      clock;
    logic                      rst;
    logic [15:0]               instr_word;
    logic [15:0]               prog_addr;
    logic [7:0]                file_rd_data;
    logic [7:0]                file_rd_addr;
    nrre_pkg::nrre_mem_wr_type file_wr;
    logic [15:0]               stack_top;
    logic                      stack_pop;
    logic [7:0]                working_reg;
    logic [7:0]                cpu_status_reg;
    logic [7:0]                alu_status_reg;
    logic [7:0]                pc_high_latch;
    logic [1:0]                q_phase;
    logic                      idle_cycle;
    logic [15:0]               pa;
    logic [15:0]               st;
    logic [7:0]                w0;
    logic [7:0]                f0;
    int                        n_fail;
    int                        compares;
    nrre_core dut (.clock, .rst, .instr_word, .prog_addr, .file_rd_data, .file_rd_addr,
        .file_wr, .stack_top, .stack_pop, .working_reg, .cpu_status_reg, .alu_status_reg,
        .pc_high_latch, .q_phase, .idle_cycle);
    nrre_mem_model mem_m (.clock, .file_rd_addr, .file_rd_data, .file_wr, .stack_top,
        .stack_pop);
    // 200 MHz clock
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end
    // Offer a word until taken, note state, wait for its results
    task automatic run(input logic [15:0] w);
        do begin
            @(posedge clock);
            instr_word <= w;
            #1;
        end while (q_phase !== 2'h0 || idle_cycle !== 1'b0);
        pa = prog_addr;
        st = stack_top;
        w0 = working_reg;
        f0 = alu_status_reg;
        @(posedge clock);
        instr_word <= 16'h0000;
        // Results land on the third edge; pulses stand only in phase 0
        repeat (3) @(posedge clock);
        #1;
    endtask
    // Return or return from interrupt, then its idle cycle
    task automatic t_return(input logic [15:0] w);
        logic [7:0] cs;
        cs = cpu_status_reg;
        run(w);
        `CHK({prog_addr, stack_pop, idle_cycle}, {st, 2'b11})
        `CHK({working_reg, alu_status_reg}, {w0, f0})
        `CHK(cpu_status_reg, (w == 16'h0005) ? (cs & 8'hef) : cs)
        repeat (4) @(posedge clock);
        #1;
        `CHK({prog_addr, idle_cycle}, {st, 1'b0})
    endtask
    // No-op leaves everything but the pc alone
    task automatic t_nop();
        run(16'h0000);
        `CHK({working_reg, alu_status_reg, stack_pop, file_wr.write_en}, {w0, f0, 2'b00})
        `CHK(prog_addr, pa + 16'h0001)
    endtask
    // Load working by literal return, then negate it
    task automatic t_negate(input logic [7:0] v, input logic s, input logic [7:0] f);
        logic [8:0] n;
        n = {1'b0, ~v} + 9'h001;
        run({8'hb6, v});
        `CHK({working_reg, prog_addr, alu_status_reg}, {v, st, f0})
        `CHK(pc_high_latch, 8'h00)
        run({7'h16, s, f});
        `CHK(working_reg, s ? v : n[7:0])
        `CHK({file_rd_addr, file_wr}, {f, 1'b1, f, n[7:0]})
        `CHK(alu_status_reg, {4'h0, v == 8'h80, n[7:0] == 8'h00, v[3:0] == 4'h0, n[8]})
        `CHK(prog_addr, pa + 16'h0001)
    endtask
    // Rotate one location; k selects through-carry left, plain left, right
    task automatic t_rotate(input int k, input logic d);
        logic [7:0] m;
        logic [7:0] r;
        logic       c;
        logic       e;
        @(posedge clock);
        #1;
        m = mem_m.mem[8'h41];
        c = alu_status_reg[0];
        r = (k == 2) ? {c, m[7:1]} : {m[6:0], (k == 0) ? c : m[7]};
        run({(k == 0) ? 7'h0d : (k == 1) ? 7'h11 : 7'h0c, d, 8'h41});
        `CHK({working_reg, file_wr.write_en}, {d ? w0 : r, d})
        if (d) `CHK({file_wr.addr, file_wr.data}, {8'h41, r})
        // Plain rotate keeps the carry, the others take the bit shifted out
        e = (k == 1) ? c : (k == 0) ? m[7] : m[0];
        `CHK(alu_status_reg, {f0[7:1], e})
    endtask
    // Closing verdict
    task automatic print_verdict();
        if (n_fail == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // Main sequence
    initial begin
        n_fail = 0;
        compares = 0;
        rst = 1'b1;
        instr_word = 16'h0000;
        repeat (2) @(posedge clock);
        `CHK({cpu_status_reg, prog_addr, working_reg}, {8'h10, 16'h0000, 8'h00})
        rst <= 1'b0;
        t_return(16'h0002);
        t_return(16'h0005);
        t_nop();
        t_negate(8'h3a, 1'b0, 8'h05);
        t_negate(8'h00, 1'b1, 8'h06);
        t_negate(8'h80, 1'b0, 8'h07);
        for (int k = 0; k < 3; k++) begin
            t_rotate(k, 1'b0);
            t_rotate(k, 1'b1);
        end
        print_verdict();
    end
    // Watchdog against a hang
    initial begin
        #10000;
        n_fail++;
        print_verdict();
    end
endmodule
